// ==== design/upsc_pkg.sv ====
/*
  Shared constants and types for the USB power, suspend and resume control.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package upsc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] POWER_IDX = 12'h001;
  localparam logic [ADDR_W-1:0] MODE_IDX = 12'h002;
  localparam logic [ADDR_W-1:0] POWER_ADDR = POWER_IDX << 2;
  localparam logic [ADDR_W-1:0] MODE_ADDR = MODE_IDX << 2;
  // Power control field positions
  localparam int unsigned ISO_BIT = 7;
  localparam int unsigned SOFT_BIT = 6;
  localparam int unsigned BUSRST_BIT = 3;
  localparam int unsigned RESUME_BIT = 2;
  localparam int unsigned SUSPEND_BIT = 1;
  localparam int unsigned PWRDN_BIT = 0;
  localparam int unsigned HOST_BIT = 0;
  // Reserved fields and reset value
  localparam logic [3:0] HOST_RSVD = 4'h2;
  localparam logic [1:0] DEV_RSVD = 2'h2;
  localparam logic [REG_W-1:0] POWER_RESET = 8'h20;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [DATA_W-REG_W-1:0] ZERO_HIGH = 24'h00_0000;
  // Resume durations software must keep
  localparam int unsigned RESUME_HOST_MS = 20;
  localparam int unsigned RESUME_DEV_NOM_MS = 10;
  localparam int unsigned RESUME_DEV_MAX_MS = 15;

  typedef enum logic [1:0] {
    ISO_IDLE = 2'b00,
    ISO_WAIT_SOF = 2'b01,
    ISO_ARMED = 2'b10
  } upsc_iso_state_t;
endpackage

// ==== design/upsc_iso_if.sv ====
/*
  Carrier between the power control and the isochronous transmit gate.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface upsc_iso_if;
  logic frameWaitEn;
  logic txPacketReady;
  logic epIsIso;
  logic sofToken;
  logic inToken;
  logic sendPacket;
  logic sendZeroLen;
  modport ctrl (
    output frameWaitEn, txPacketReady, epIsIso, sofToken, inToken,
    input sendPacket, sendZeroLen
  );
  modport gate (
    input frameWaitEn, txPacketReady, epIsIso, sofToken, inToken,
    output sendPacket, sendZeroLen
  );
endinterface
`default_nettype wire

// ==== design/upsc_iso_gate.sv ====
/*
  Transmit gate that holds an isochronous packet until the next start of
  frame. Assumes token inputs are one-cycle pulses on the controller clock.
*/
`timescale 1ns/1ps
`default_nettype none
module upsc_iso_gate
  import upsc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link to the power control
  upsc_iso_if.gate iso
);
  upsc_iso_state_t state_q;
  upsc_iso_state_t state_d;
  logic gated;
  logic holding;
  logic sendPacket_q;
  logic sendZeroLen_q;
  logic pktNow;
  logic zeroNow;

  // Only isochronous endpoints are ever held back
  assign gated = iso.frameWaitEn & iso.epIsIso;
  // A held packet is released the moment the enable or ready drops
  assign holding = gated & iso.txPacketReady;

  always_comb begin
    state_d = state_q;
    pktNow = 1'b0;
    zeroNow = 1'b0;
    case (state_q)
      ISO_IDLE: begin
        if (gated & iso.txPacketReady) begin
          state_d = ISO_WAIT_SOF;
          if (iso.sofToken) begin
            state_d = ISO_ARMED;
          end
          if (iso.inToken) begin
            zeroNow = 1'b1;
          end
        end else if (iso.txPacketReady & iso.inToken) begin
          pktNow = 1'b1;
        end
      end
      ISO_WAIT_SOF: begin
        if (!holding) begin
          pktNow = iso.txPacketReady & iso.inToken;
        end else if (iso.sofToken) begin
          state_d = ISO_ARMED;
        end else if (iso.inToken) begin
          zeroNow = 1'b1;
        end
      end
      ISO_ARMED: begin
        if (iso.inToken & iso.txPacketReady) begin
          pktNow = 1'b1;
          state_d = ISO_IDLE;
        end
      end
      default: begin
        state_d = ISO_IDLE;
      end
    endcase
    // Dropping the enable or the ready flag releases a held packet
    if (!gated | !iso.txPacketReady) begin
      if (state_q != ISO_IDLE) begin
        state_d = ISO_IDLE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ISO_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sendPacket_q <= 1'b0;
      sendZeroLen_q <= 1'b0;
    end else begin
      sendPacket_q <= pktNow;
      sendZeroLen_q <= zeroNow;
    end
  end

  assign iso.sendPacket = sendPacket_q;
  assign iso.sendZeroLen = sendZeroLen_q;
endmodule
`default_nettype wire

// ==== design/usb_power_suspend_resume_ctrl.sv ====
/*
  USB power control register with suspend, resume, bus reset, transceiver
  power-down, soft connect and isochronous frame wait, behind APB.
  Assumes link inputs are synchronous to clock and events are pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_power_suspend_resume_ctrl
  import upsc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [upsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [upsc_pkg::DATA_W-1:0] pwdata,
  output logic [upsc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus events seen by the transceiver
  input wire logic busResetDetect,
  input wire logic suspendDetect,
  input wire logic intStatusRead,
  // Endpoint transmit side
  input wire logic txPacketReady,
  input wire logic epIsIso,
  input wire logic sofToken,
  input wire logic inToken,
  output logic sendPacket,
  output logic sendZeroLen,
  // Line and transceiver control
  output logic busResetDrive,
  output logic resumeDrive,
  output logic suspendActive,
  output logic phyPowerDown,
  output logic dataLineOe,
  output logic hostMode
);
  logic hostMode_q;
  logic busReset_q;
  logic resume_q;
  logic resumeActive_q;
  logic suspend_q;
  logic pwrDown_q;
  logic isoWait_q;
  logic softConnect_q;
  logic lineOe_q;
  logic busRstDrv_q;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] rdWord;
  logic [REG_W-1:0] powerRead;
  logic setupRead;
  logic wrStrobe;
  logic wrPower;
  logic wrMode;
  logic mapped;
  logic resumeSet;
  logic suspendClr;
  logic suspendSet;
  logic deviceMode;
  logic leaveHost;

  upsc_iso_if isoLink();

  // Bus decode; zero wait states, unmapped addresses answer an error
  assign mapped = (paddr == POWER_ADDR) | (paddr == MODE_ADDR);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wrStrobe = psel & penable & pwrite;
  assign wrPower = wrStrobe & (paddr == POWER_ADDR);
  assign wrMode = wrStrobe & (paddr == MODE_ADDR);
  assign setupRead = psel & ~penable & ~pwrite;

  assign deviceMode = ~hostMode_q;

  // Drive must not outlive host mode by the register's extra cycle
  assign leaveHost = wrMode & ~pwdata[HOST_BIT];

  // Host-mode select; reset leaves the device layout in force
  always_ff @(posedge clock) begin
    if (rst) begin
      hostMode_q <= 1'b0;
    end else if (wrMode) begin
      hostMode_q <= pwdata[HOST_BIT];
    end
  end

  // Bus reset control only exists in host mode
  always_ff @(posedge clock) begin
    if (rst) begin
      busReset_q <= POWER_RESET[BUSRST_BIT];
    end else if (wrPower & hostMode_q) begin
      busReset_q <= pwdata[BUSRST_BIT];
    end else if (deviceMode) begin
      busReset_q <= 1'b0;
    end
  end

  // Software times the resume pulse; hardware does not end it
  assign resumeSet = wrPower & pwdata[RESUME_BIT] & ~resume_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      resume_q <= POWER_RESET[RESUME_BIT];
    end else if (wrPower) begin
      resume_q <= pwdata[RESUME_BIT];
    end
  end

  // Resume is driven only if the set found the link suspended
  always_ff @(posedge clock) begin
    if (rst) begin
      resumeActive_q <= 1'b0;
    end else if (wrPower & ~pwdata[RESUME_BIT]) begin
      resumeActive_q <= 1'b0;
    end else if (resumeSet & suspend_q) begin
      resumeActive_q <= 1'b1;
    end
  end

  // Suspend: host writes one to set, device follows the bus
  assign suspendSet = hostMode_q ? (wrPower & pwdata[SUSPEND_BIT])
                                 : suspendDetect;
  assign suspendClr = resumeSet | (deviceMode & intStatusRead);

  always_ff @(posedge clock) begin
    if (rst) begin
      suspend_q <= POWER_RESET[SUSPEND_BIT];
    end else if (suspendSet) begin
      suspend_q <= 1'b1; // Set wins over a same-cycle clear
    end else if (suspendClr) begin
      suspend_q <= 1'b0;
    end
  end

  // Transceiver power-down; zero simply leaves the transceiver running
  always_ff @(posedge clock) begin
    if (rst) begin
      pwrDown_q <= POWER_RESET[PWRDN_BIT];
    end else if (wrPower) begin
      pwrDown_q <= pwdata[PWRDN_BIT];
    end
  end

  // Device-only fields; host writes there hit reserved bits
  always_ff @(posedge clock) begin
    if (rst) begin
      isoWait_q <= POWER_RESET[ISO_BIT];
      softConnect_q <= POWER_RESET[SOFT_BIT];
    end else if (wrPower & deviceMode) begin
      isoWait_q <= pwdata[ISO_BIT];
      softConnect_q <= pwdata[SOFT_BIT];
    end
  end

  // Registered line drive; host mode always drives the lines
  always_ff @(posedge clock) begin
    if (rst) begin
      lineOe_q <= 1'b0;
      busRstDrv_q <= 1'b0;
    end else begin
      lineOe_q <= hostMode_q | softConnect_q;
      busRstDrv_q <= hostMode_q & busReset_q & ~leaveHost;
    end
  end

  // Read view depends on the active layout
  always_comb begin
    if (hostMode_q) begin
      powerRead = {HOST_RSVD, busReset_q, resume_q, suspend_q, pwrDown_q};
    end else begin
      powerRead = {isoWait_q, softConnect_q, DEV_RSVD,
                   busResetDetect, resume_q, suspend_q, pwrDown_q};
    end
  end

  always_comb begin
    rdWord = ZERO_WORD;
    if (paddr == POWER_ADDR) begin
      rdWord = {ZERO_HIGH, powerRead};
    end else if (paddr == MODE_ADDR) begin
      rdWord[HOST_BIT] = hostMode_q;
    end
  end

  // Read data captured in setup so it comes from a flip-flop
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata_q <= ZERO_WORD;
    end else if (setupRead) begin
      prdata_q <= rdWord;
    end
  end

  // Isochronous transmit gate, device mode only
  assign isoLink.frameWaitEn = isoWait_q & deviceMode;
  assign isoLink.txPacketReady = txPacketReady;
  assign isoLink.epIsIso = epIsIso;
  assign isoLink.sofToken = sofToken;
  assign isoLink.inToken = inToken;

  upsc_iso_gate isoGate (
    .clock(clock),
    .rst(rst),
    .iso(isoLink.gate)
  );

  assign prdata = prdata_q;
  assign sendPacket = isoLink.sendPacket;
  assign sendZeroLen = isoLink.sendZeroLen;
  assign busResetDrive = busRstDrv_q;
  assign resumeDrive = resumeActive_q;
  assign suspendActive = suspend_q;
  assign phyPowerDown = pwrDown_q;
  assign dataLineOe = lineOe_q;
  assign hostMode = hostMode_q;
endmodule
`default_nettype wire

// ==== testbench/upsc_properties.sv ====
/*
  Port checker for the power control block.
  Bound from tb_top; sees only the top ports.
*/
`timescale 1ns/1ps
`default_nettype none
module upsc_properties
  import upsc_pkg::*;
(
  // Watched ports
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [upsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [upsc_pkg::DATA_W-1:0] pwdata,
  input wire logic [upsc_pkg::DATA_W-1:0] prdata,
  input wire logic busResetDetect,
  input wire logic txPacketReady,
  input wire logic epIsIso,
  input wire logic inToken,
  input wire logic sendPacket,
  input wire logic sendZeroLen,
  input wire logic busResetDrive,
  input wire logic resumeDrive,
  input wire logic suspendActive,
  input wire logic phyPowerDown,
  input wire logic dataLineOe,
  input wire logic hostMode
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence powWr;
    psel && penable && pwrite && paddr == POWER_ADDR;
  endsequence
  sequence powRd;
    psel && !penable && !pwrite && paddr == POWER_ADDR;
  endsequence
  mode_after_reset_a: assert property ($fell(rst) |-> !hostMode)
    else $error("host mode after reset");
  bus_reset_host_a: assert property (busResetDrive |-> hostMode)
    else $error("bus reset driven in device mode");
  resume_needs_susp_a: assert property ($rose(resumeDrive) |->
    $past(suspendActive)) else $error("resume without suspend");
  susp_set_a: assert property (powWr ##0 (hostMode &&
    pwdata[SUSPEND_BIT]) |-> ##[1:2] suspendActive) else $error("no suspend");
  susp_hold_a: assert property (powWr ##0 (hostMode &&
    pwdata[2:1] == 2'h0) |=> $stable(suspendActive))
    else $error("suspend moved");
  pwr_down_a: assert property (powWr ##0 pwdata[PWRDN_BIT] |->
    ##[1:2] phyPowerDown) else $error("no power down");
  lines_float_a: assert property (powWr ##0 (!hostMode &&
    !pwdata[SOFT_BIT]) |-> ##[1:3] !dataLineOe) else $error("lines driven");
  reset_status_a: assert property (powRd ##0 !hostMode |=>
    prdata[BUSRST_BIT] == $past(busResetDetect)) else $error("reset status");
  rsvd_field_a: assert property (powRd |=> prdata[5:4] == 2'h2 &&
    prdata[31:8] == ZERO_HIGH) else $error("reserved field");
  zero_len_a: assert property (sendZeroLen |-> $past(inToken &&
    epIsIso && txPacketReady && !hostMode)) else $error("stray zero length");
  iso_send_a: assert property (sendPacket |->
    $past(inToken && txPacketReady)) else $error("stray packet");
endmodule
`default_nettype wire

// ==== testbench/upsc_usb_peer.sv ====
/*
  Bus peer model: sends tokens and line events.
  Assumes requests last one clock cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module upsc_usb_peer (
  // Clock
  input wire logic clock,
  // Request: 1 sof, 2 in, 3 suspend, 4 reset on, 5 reset off
  input wire logic [2:0] cmd,
  // Bus events
  output logic sofToken,
  output logic inToken,
  output logic suspendDetect,
  output logic busResetDetect
);
  initial {sofToken, inToken, suspendDetect, busResetDetect} = 4'h0;
  // Tokens are one-cycle pulses, reset is a level
  always @(posedge clock) begin
    sofToken <= cmd == 3'h1;
    inToken <= cmd == 3'h2;
    suspendDetect <= cmd == 3'h3;
    if (cmd == 3'h4) busResetDetect <= 1'h1;
    else if (cmd == 3'h5) busResetDetect <= 1'h0;
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench with a register model.
  Assumes zero-wait APB and the peer model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import upsc_pkg::*;
  logic clock, rst, psel, penable, pwrite, intStatusRead, txPacketReady;
  logic epIsIso, sofToken, inToken, suspendDetect, busResetDetect, er;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic pready, pslverr, sendPacket, sendZeroLen, busResetDrive;
  logic resumeDrive, suspendActive, phyPowerDown, dataLineOe, hostMode;
  logic [2:0] cmd;
  logic mIso, mSc, mRes, mSusp, mPd, mHost, mBr, mDrv;
  int mismatches, tests_run, seed, i, sawP, sawZ;
  logic [31:0] expQ[$];
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  usb_power_suspend_resume_ctrl DUT (.clock, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busResetDetect,
    .suspendDetect, .intStatusRead, .txPacketReady, .epIsIso, .sofToken,
    .inToken, .sendPacket, .sendZeroLen, .busResetDrive, .resumeDrive,
    .suspendActive, .phyPowerDown, .dataLineOe, .hostMode);
  upsc_usb_peer peer (.clock, .cmd, .sofToken, .inToken, .suspendDetect,
    .busResetDetect);
  task conclude;
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge clock);
  endtask
  function logic [31:0] expPow();
    if (mHost) return {24'h0, 4'h2, mBr, mRes, mSusp, mPd};
    return {24'h0, mIso, mSc, 2'h2, busResetDetect, mRes, mSusp, mPd};
  endfunction
  task rp;
    apb(1'h0, POWER_ADDR, ZERO_WORD);
    expQ.push_back(expPow());
    chk(rd, expQ.pop_front());
  endtask
  // Set wins over the resume clear, so the set goes last
  task wp(input logic [7:0] d);
    apb(1'h1, POWER_ADDR, {24'h0, d});
    if (d[2] && !mRes) {mDrv, mSusp} = {mSusp, 1'h0};
    if (!d[2]) mDrv = 1'h0;
    mRes = d[2];
    mPd = d[0];
    if (mHost) {mBr, mSusp} = {d[3], mSusp | d[1]};
    else {mIso, mSc} = d[7:6];
    repeat (2) @(posedge clock);
    chk(32'(busResetDrive), 32'(mBr));
    chk(32'(resumeDrive), 32'(mDrv));
    chk(32'(suspendActive), 32'(mSusp));
    chk(32'(phyPowerDown), 32'(mPd));
    chk(32'(dataLineOe), 32'(mHost | mSc));
    chk(32'(hostMode), 32'(mHost));
  endtask
  task ev(input logic [2:0] c);
    cmd <= c;
    @(posedge clock);
    cmd <= 3'h0;
    @(posedge clock);
  endtask
  task tok(input logic [2:0] c, input int z, input int p);
    ev(c);
    {sawZ, sawP} = 64'h0;
    repeat (4) begin
      @(posedge clock);
      if (sendZeroLen !== 1'h0) sawZ++;
      if (sendPacket !== 1'h0) sawP++;
    end
    chk(32'(sawZ), 32'(z));
    chk(32'(sawP), 32'(p));
  endtask
  initial begin
    {rst, psel, penable, pwrite, intStatusRead, txPacketReady} = 6'h20;
    {epIsIso, paddr, pwdata, cmd} = 0;
    {mIso, mSc, mRes, mSusp, mPd, mHost, mBr, mDrv} = 8'h0;
    {mismatches, tests_run, seed} = {32'h0, 32'h0, 32'h8cf02350};
    repeat (12) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    rp();
    apb(1'h0, MODE_ADDR, ZERO_WORD);
    chk(rd, ZERO_WORD);
    for (i = 0; i < 6; i++) begin
      rd = $random(seed);
      wp(rd[7:0] & 8'hc1);
      rp();
    end
    ev(3'h4);
    wp(8'h48);
    rp();
    ev(3'h5);
    ev(3'h3);
    repeat (3) @(posedge clock);
    mSusp = 1'h1;
    rp();
    intStatusRead <= 1'h1;
    @(posedge clock);
    intStatusRead <= 1'h0;
    mSusp = 1'h0;
    repeat (2) @(posedge clock);
    rp();
    ev(3'h3);
    repeat (3) @(posedge clock);
    mSusp = 1'h1;
    wp(8'h44);
    wp(8'h40);
    wp(8'h44);
    {txPacketReady, epIsIso} <= 2'h3;
    wp(8'hc0);
    tok(3'h2, 1, 0);
    tok(3'h1, 0, 0);
    tok(3'h2, 0, 1);
    epIsIso <= 1'h0;
    tok(3'h2, 0, 1);
    wp(8'h40);
    epIsIso <= 1'h1;
    tok(3'h2, 0, 1);
    txPacketReady <= 1'h0;
    tok(3'h2, 0, 0);
    apb(1'h1, 12'hffc, 32'hff);
    chk(32'(er), 32'h1);
    apb(1'h0, 12'hffc, ZERO_WORD);
    chk({rd[31:1], er}, 32'h1);
    apb(1'h1, MODE_ADDR, 32'h1);
    mHost = 1'h1;
    rp();
    wp(8'hc8);
    wp(8'h00);
    wp(8'h02);
    wp(8'h00);
    rp();
    wp(8'h04);
    wp(8'h00);
    rp();
    conclude();
  end
endmodule
bind usb_power_suspend_resume_ctrl upsc_properties chk_i (.clock, .rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .busResetDetect,
  .txPacketReady, .epIsIso, .inToken, .sendPacket, .sendZeroLen,
  .busResetDrive, .resumeDrive, .suspendActive, .phyPowerDown, .dataLineOe,
  .hostMode);
`default_nettype wire
